// [hdl/pcg_clock_gate.sv]
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
// peripheral clock gating registers behind an ahb-lite slave
module pcg_clock_gate
  import pcg_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  // timer clock enables
  output logic timer_a_ch0_clock_on,
  output logic timer_a_ch1_clock_on,
  output logic timer_pair_a_clock_on,
  output logic timer_pair_b_clock_on,
  // serial clock enables
  output logic async_port_0_clock_on,
  output logic async_port_1_clock_on,
  output logic two_wire_bus_clock_on,
  // calendar and synchronous serial enables
  output logic sync_serial_clock_on,
  output logic calendar_clock_on,
  // external interrupt input enables
  output logic ext_irq0_clock_on,
  output logic ext_irq1_clock_on,
  output logic ext_irq2_clock_on,
  output logic ext_irq3_clock_on,
  output logic ext_irq4_clock_on,
  output logic ext_irq5_clock_on
);
  typedef struct packed {
    logic [3:0][7:0] gate; // the four clock gate registers
    logic wr_pend; // write waiting for its data phase
    logic [1:0] wr_sel; // register of that pending write
    logic [31:0] rdata; // read data for the data phase
    logic ready; // hreadyout
    logic [1:0] resp; // hresp
  } pcg_state_t;

  pcg_state_t cur_reg;
  pcg_state_t cur_next;
  logic take; // address phase accepted this cycle
  logic hit; // address phase names a gate register
  logic [1:0] sel; // which gate register
  logic [NUM_GATES-1:0] ce_vec; // registered enables from the cells

  // address decode on the word index; everything else is unmapped
  always_comb begin
    hit = 1'b1;
    sel = SEL_TIMER;
    case (haddr[31:2])
      IDX_TIMER: begin
        sel = SEL_TIMER;
      end
      IDX_SERIAL: begin
        sel = SEL_SERIAL;
      end
      IDX_RTC_SIO: begin
        sel = SEL_RTC_SIO;
      end
      IDX_EXT_IRQ: begin
        sel = SEL_EXT_IRQ;
      end
      default: begin
        hit = 1'b0; // unmapped: reads zero, writes dropped
      end
    endcase
  end

  // bus slave and register file
  always_comb begin
    take = hsel && htrans[1] && hready;
    cur_next = cur_reg;
    cur_next.ready = 1'b1; // zero wait states, always
    cur_next.resp = HRESP_OKAY;
    cur_next.wr_pend = 1'b0;
    // data phase of an earlier write; all eight bits store, spare ones too
    if (cur_reg.wr_pend) begin
      cur_next.gate[cur_reg.wr_sel] = hwdata[7:0];
    end
    if (take && hwrite && hit) begin
      cur_next.wr_pend = 1'b1;
      cur_next.wr_sel = sel;
    end
    // read data taken from the next value so a write just ahead is seen
    if (take && !hwrite) begin
      if (hit) begin
        cur_next.rdata = {24'h000000, cur_next.gate[sel]};
      end else begin
        cur_next.rdata = RDATA_ZERO;
      end
    end
  end

  // the one state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_reg.gate <= {4{GATE_RESET}};
      cur_reg.wr_pend <= 1'b0;
      cur_reg.wr_sel <= SEL_TIMER;
      cur_reg.rdata <= RDATA_ZERO;
      cur_reg.ready <= 1'b1;
      cur_reg.resp <= HRESP_OKAY;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign hrdata = cur_reg.rdata;
  assign hreadyout = cur_reg.ready;
  assign hresp = cur_reg.resp;

  // one enable cell per gated peripheral, picked from the map
  // the enable lags the register by one cycle; peripherals see a clean edge
  generate
    for (genvar g = 0; g < NUM_GATES; g++) begin : gen_gate
      pcg_gate_cell u_pcg_gate_cell (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable_in(cur_reg.gate[GATE_SEL[g]][GATE_POS[g]]),
        .clock_on(ce_vec[g])
      );
    end
  endgenerate

  // named outputs straight from the cell flip-flops
  assign timer_a_ch0_clock_on = ce_vec[0];
  assign timer_a_ch1_clock_on = ce_vec[1];
  assign timer_pair_a_clock_on = ce_vec[2];
  assign timer_pair_b_clock_on = ce_vec[3];
  assign async_port_0_clock_on = ce_vec[4];
  assign async_port_1_clock_on = ce_vec[5];
  assign two_wire_bus_clock_on = ce_vec[6];
  assign sync_serial_clock_on = ce_vec[7];
  assign calendar_clock_on = ce_vec[8];
  assign ext_irq0_clock_on = ce_vec[9];
  assign ext_irq1_clock_on = ce_vec[10];
  assign ext_irq2_clock_on = ce_vec[11];
  assign ext_irq3_clock_on = ce_vec[12];
  assign ext_irq4_clock_on = ce_vec[13];
  assign ext_irq5_clock_on = ce_vec[14];

  chk_reset_all_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> (cur_reg.gate == 32'h00000000) && (ce_vec == 15'h0000))
    else $error("gate registers not clear after reset");

  chk_timer_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur_reg.wr_pend && cur_reg.wr_sel == SEL_TIMER) |=> cur_reg.gate[0] == $past(hwdata[7:0]))
    else $error("timer gate register did not take write");

  chk_serial_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur_reg.wr_pend && cur_reg.wr_sel == SEL_SERIAL) |=> cur_reg.gate[1] == $past(hwdata[7:0]))
    else $error("serial gate register did not take write");

  chk_rtc_sio_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur_reg.wr_pend && cur_reg.wr_sel == SEL_RTC_SIO) |=> cur_reg.gate[2] == $past(hwdata[7:0]))
    else $error("calendar and sync serial register did not take write");

  chk_ext_irq_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur_reg.wr_pend && cur_reg.wr_sel == SEL_EXT_IRQ) |=> cur_reg.gate[3] == $past(hwdata[7:0]))
    else $error("external interrupt gate register did not take write");

  chk_timer_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && haddr[31:2] == IDX_TIMER && !cur_reg.wr_pend)
      |=> hrdata == {24'h000000, $past(cur_reg.gate[0])})
    else $error("timer gate register read back wrong");

  chk_calendar_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    cur_reg.gate[2][POS_CALENDAR] ##1 cur_reg.gate[2][POS_CALENDAR] |-> calendar_clock_on)
    else $error("calendar enable not following its bit");

  chk_irq5_stops: assert property (@(posedge hclk) disable iff (!hresetn)
    !cur_reg.gate[3][5] |=> !ext_irq5_clock_on)
    else $error("interrupt input 5 enable on while gated off");
endmodule

// [pkg/pcg_pkg.sv]
// Notes on behaviour
// - gate bit zero stops that peripheral clock
// - gate bit one supplies that peripheral clock
// - all gate bits clear at reset
// - timer register gates two pairs, two channels
// - serial register gates two-wire bus, two ports
// - third register gates calendar and sync serial
// - fourth register gates six external interrupt inputs
package pcg_pkg;
  // register indices; byte address is four times the index
  localparam logic [29:0] IDX_TIMER = 30'h00000f74;
  localparam logic [29:0] IDX_SERIAL = 30'h00000f75;
  localparam logic [29:0] IDX_RTC_SIO = 30'h00000f76;
  localparam logic [29:0] IDX_EXT_IRQ = 30'h00000f77;
  // register selects inside the gate array
  localparam logic [1:0] SEL_TIMER = 2'h0;
  localparam logic [1:0] SEL_SERIAL = 2'h1;
  localparam logic [1:0] SEL_RTC_SIO = 2'h2;
  localparam logic [1:0] SEL_EXT_IRQ = 2'h3;
  // every gate register clears to this
  localparam logic [7:0] GATE_RESET = 8'h00;
  // ahb encodings
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [31:0] RDATA_ZERO = 32'h00000000;
  // field positions
  localparam logic [2:0] POS_TMR_A0 = 3'h0;
  localparam logic [2:0] POS_TMR_A1 = 3'h1;
  localparam logic [2:0] POS_PAIR_A = 3'h4;
  localparam logic [2:0] POS_PAIR_B = 3'h5;
  localparam logic [2:0] POS_ASYNC0 = 3'h0;
  localparam logic [2:0] POS_ASYNC1 = 3'h1;
  localparam logic [2:0] POS_TWO_WIRE = 3'h4;
  localparam logic [2:0] POS_SYNC_SER = 3'h0;
  localparam logic [2:0] POS_CALENDAR = 3'h4;
  // gated clock map, entry g = register select and bit position
  localparam int NUM_GATES = 15;
  localparam logic [14:0][1:0] GATE_SEL = {
    SEL_EXT_IRQ, SEL_EXT_IRQ, SEL_EXT_IRQ, SEL_EXT_IRQ, SEL_EXT_IRQ, SEL_EXT_IRQ,
    SEL_RTC_SIO, SEL_RTC_SIO,
    SEL_SERIAL, SEL_SERIAL, SEL_SERIAL,
    SEL_TIMER, SEL_TIMER, SEL_TIMER, SEL_TIMER};
  localparam logic [14:0][2:0] GATE_POS = {
    3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0,
    POS_CALENDAR, POS_SYNC_SER,
    POS_TWO_WIRE, POS_ASYNC1, POS_ASYNC0,
    POS_PAIR_B, POS_PAIR_A, POS_TMR_A1, POS_TMR_A0};
endpackage

// [hdl/pcg_gate_cell.sv]
`timescale 1ns/1ps
// one synchronous clock enable for one peripheral
module pcg_gate_cell
  import pcg_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // gate bit from the register file
  input wire logic enable_in,
  // registered enable towards the peripheral
  output logic clock_on
);
  typedef struct packed {
    logic on; // enable seen by the peripheral
  } pcg_cell_state_t;

  pcg_cell_state_t cur_reg;
  pcg_cell_state_t cur_next;

  // an enable, not a gated clock: no combinational path can make a runt edge
  always_comb begin
    cur_next = cur_reg;
    cur_next.on = enable_in;
  end

  // register the enable on the system clock only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign clock_on = cur_reg.on;

  chk_off_stops_clock: assert property (@(posedge hclk) disable iff (!hresetn)
    !enable_in |=> !clock_on)
    else $error("clock enable still on after gate bit cleared");

  chk_on_supplies_clock: assert property (@(posedge hclk) disable iff (!hresetn)
    enable_in |=> clock_on)
    else $error("clock enable missing after gate bit set");

  chk_no_runt_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(clock_on) |-> clock_on == $past(enable_in))
    else $error("clock enable changed without a cause");
endmodule

// [dv/pcg_periph_model.sv]
`timescale 1ns/1ps
// stand-in for the fifteen gated peripherals: each counts its own clock ticks
module pcg_periph_model
  import pcg_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // clock enables from the gating block
  input wire logic [14:0] clock_on,
  // tick count seen by each peripheral
  output logic [14:0][7:0] ticks
);
  // a peripheral only advances on cycles where its clock is supplied
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ticks <= '0;
    end else begin
      for (int g = 0; g < NUM_GATES; g++) begin
        if (clock_on[g]) begin
          ticks[g] <= ticks[g] + 8'h01;
        end
      end
    end
  end
endmodule

// [dv/test_peripheral_clock_gating.sv]
`timescale 1ns/1ps
// register-level test of the clock gate block over ahb-lite
module test_peripheral_clock_gating;
  import pcg_pkg::*;
  // bus and clocking
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic [1:0] hresp;
  logic hready_w;
  // gated enables and peripheral tick counts
  logic [14:0] en;
  logic [14:0][7:0] ticks;
  // bookkeeping
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [29:0] idx [4] = '{IDX_TIMER, IDX_SERIAL, IDX_RTC_SIO, IDX_EXT_IRQ};
  logic [7:0] gs [4];

  always #2.5 hclk = ~hclk;

  // hready is looped back: the one slave drives the bus ready
  pcg_clock_gate u_pcg_clock_gate (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready_w),
    .hrdata(hrdata), .hreadyout(hready_w), .hresp(hresp),
    .timer_a_ch0_clock_on(en[0]), .timer_a_ch1_clock_on(en[1]),
    .timer_pair_a_clock_on(en[2]), .timer_pair_b_clock_on(en[3]),
    .async_port_0_clock_on(en[4]), .async_port_1_clock_on(en[5]),
    .two_wire_bus_clock_on(en[6]), .sync_serial_clock_on(en[7]),
    .calendar_clock_on(en[8]), .ext_irq0_clock_on(en[9]), .ext_irq1_clock_on(en[10]),
    .ext_irq2_clock_on(en[11]), .ext_irq3_clock_on(en[12]), .ext_irq4_clock_on(en[13]),
    .ext_irq5_clock_on(en[14]));

  pcg_periph_model u_pcg_periph_model (
    .hclk(hclk), .hresetn(hresetn), .clock_on(en), .ticks(ticks));

  // verdict and end of run, reached from the sequence or the watchdog
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one single transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready_w !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready_w !== 1'b1);
    q = hrdata;
  endtask

  // enables expected from the gate register images
  function automatic logic [14:0] exp_en();
    logic [14:0] e;
    for (int g = 0; g < NUM_GATES; g++) begin
      e[g] = gs[GATE_SEL[g]][GATE_POS[g]];
    end
    return e;
  endfunction

  // watchdog: the whole sequence needs well under a few hundred cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    logic [31:0] q;
    logic [14:0][7:0] t0;
    logic [14:0] want;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(32'(en), 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, {idx[i], 2'b00}, 32'h0, q);
      check(q, 32'h0);
    end
    // unmapped word: write dropped, reads zero, response okay and ready high
    bus(1'b1, 32'h00003de0, 32'hffffffff, q);
    bus(1'b0, 32'h00003de0, 32'h0, q);
    check(q, 32'h0);
    check(32'(hresp), 32'(HRESP_OKAY));
    check(32'(hready_w), 32'h1);
    // pattern then complement: every bit set and cleared, spares too
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 4; i++) begin
        gs[i] = (r == 0) ? 8'ha5 + 8'(i) * 8'h11 : ~(8'ha5 + 8'(i) * 8'h11);
        // stand-ins run no operation that clearing a bit could cut short
        bus(1'b1, {idx[i], 2'b00}, {24'hffffff, gs[i]}, q);
      end
      for (int i = 0; i < 4; i++) begin
        bus(1'b0, {idx[i], 2'b00}, 32'h0, q);
        check(q, {24'h0, gs[i]});
      end
      want = exp_en();
      check(32'(en), 32'(want));
      // gated peripherals stand still, supplied ones advance every cycle
      t0 = ticks;
      repeat (10) @(posedge hclk);
      for (int g = 0; g < NUM_GATES; g++) begin
        check(32'(ticks[g]), 32'(8'(t0[g] + (want[g] ? 8'h0a : 8'h00))));
      end
    end
    finish_test();
  end
endmodule
